// ==== rtl/xod_pkg.sv ====
package xod_pkg;

  // ----------------------------------------------------------------
  // leading and second opcode bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PREFIX    = 8'h3c;
  localparam logic [7:0] OP_REG_MEM   = 8'h7d;
  localparam logic [7:0] OP_MEM_MEM   = 8'h2a;
  localparam logic [7:0] OP_PTR       = 8'h07;
  localparam logic [7:0] OP_ACC_SA2   = 8'h9d;
  localparam logic [7:0] SUB_REG_REG  = 8'h8d;
  localparam logic [7:0] SUB_SA2_SA2  = 8'h0d;
  localparam logic [7:0] SUB_SA2_SA1  = 8'h1d;
  localparam logic [7:0] SUB_SA1_SA2  = 8'h2d;
  localparam logic [7:0] SUB_SA1_SA1  = 8'h3d;
  localparam logic [7:0] SUB_ACC_PTR  = 8'h2d;
  localparam logic [7:0] SUB_ACC_LONG = 8'h3d;
  localparam logic [7:0] SUB_PTR_ACC  = 8'had;
  localparam logic [7:0] SUB_LONG_ACC = 8'hbd;

  // ----------------------------------------------------------------
  // low nibble of the register-with-memory second byte
  // ----------------------------------------------------------------
  localparam logic [3:0] NIB_REG_SA2 = 4'h0;
  localparam logic [3:0] NIB_REG_SA1 = 4'h1;
  localparam logic [3:0] NIB_REG_SFR = 4'h2;
  localparam logic [3:0] NIB_SA2_REG = 4'h4;
  localparam logic [3:0] NIB_SA1_REG = 4'h5;
  localparam logic [3:0] NIB_SFR_REG = 4'h6;

  // ----------------------------------------------------------------
  // field positions and counts
  // ----------------------------------------------------------------
  localparam int         REG_HI      = 7;
  localparam int         REG_LO      = 4;
  localparam int         NIB_HI      = 3;
  localparam int         RR_ZERO_BIT = 3;
  localparam int         RR_SRC_HI   = 2;
  localparam logic [1:0] OPS_NONE    = 2'h0;
  localparam logic [1:0] OPS_ONE     = 2'h1;
  localparam logic [1:0] OPS_TWO     = 2'h2;
  localparam logic [3:0] REG_RESET   = 4'h0;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  typedef enum logic [4:0] {
    F_NONE, F_REG_REG, F_REG_SA2, F_REG_SA1, F_SA2_REG, F_SA1_REG, F_REG_SFR, F_SFR_REG,
    F_SA2_SA2, F_SA2_SA1, F_SA1_SA2, F_SA1_SA1, F_ACC_SA2,
    F_ACC_PTR2, F_ACC_LONG2, F_PTR2_ACC, F_LONG2_ACC,
    F_ACC_PTR1, F_ACC_LONG1, F_PTR1_ACC, F_LONG1_ACC
  } xod_form_t;

  typedef enum logic [3:0] {
    K_NONE, K_REG, K_ACC, K_SFR, K_AREA_ONE, K_AREA_TWO,
    K_AREA_ONE_PTR, K_AREA_TWO_PTR, K_AREA_ONE_LONG_PTR, K_AREA_TWO_LONG_PTR
  } xod_kind_t;

endpackage

// ==== rtl/xod_form_table.sv ====
`timescale 1ns/10ps
module xod_form_table (
  input  wire logic              prefixed,
  input  wire logic [7:0]        leadByte,
  input  wire logic [7:0]        subByte,
  output xod_pkg::xod_form_t     form,
  output xod_pkg::xod_kind_t     dstKind,
  output xod_pkg::xod_kind_t     srcKind,
  output logic      [1:0]        opCount,
  output logic                   regInSub
);

  // ----------------------------------------------------------------
  // pure lookup; an unlisted pair leaves form at F_NONE
  // ----------------------------------------------------------------
  always_comb
  begin
    form     = xod_pkg::F_NONE;
    dstKind  = xod_pkg::K_NONE;
    srcKind  = xod_pkg::K_NONE;
    opCount  = xod_pkg::OPS_NONE;
    regInSub = 1'b0;
    case (leadByte)
      xod_pkg::OP_PREFIX:
        if (prefixed && subByte == xod_pkg::SUB_REG_REG)
        begin
          form    = xod_pkg::F_REG_REG; //RULE_01
          dstKind = xod_pkg::K_REG;
          srcKind = xod_pkg::K_REG;
          opCount = xod_pkg::OPS_ONE;
        end
      xod_pkg::OP_REG_MEM:
        if (!prefixed)
        begin
          regInSub = 1'b1;
          opCount  = xod_pkg::OPS_ONE;
          case (subByte[xod_pkg::NIB_HI:0])
            xod_pkg::NIB_REG_SA2: {form, dstKind, srcKind} =
              {xod_pkg::F_REG_SA2, xod_pkg::K_REG, xod_pkg::K_AREA_TWO}; //RULE_02
            xod_pkg::NIB_REG_SA1: {form, dstKind, srcKind} =
              {xod_pkg::F_REG_SA1, xod_pkg::K_REG, xod_pkg::K_AREA_ONE}; //RULE_03
            xod_pkg::NIB_SA2_REG: {form, dstKind, srcKind} =
              {xod_pkg::F_SA2_REG, xod_pkg::K_AREA_TWO, xod_pkg::K_REG}; //RULE_04
            xod_pkg::NIB_SA1_REG: {form, dstKind, srcKind} =
              {xod_pkg::F_SA1_REG, xod_pkg::K_AREA_ONE, xod_pkg::K_REG}; //RULE_05
            xod_pkg::NIB_REG_SFR: {form, dstKind, srcKind} =
              {xod_pkg::F_REG_SFR, xod_pkg::K_REG, xod_pkg::K_SFR}; //RULE_06
            xod_pkg::NIB_SFR_REG: {form, dstKind, srcKind} =
              {xod_pkg::F_SFR_REG, xod_pkg::K_SFR, xod_pkg::K_REG}; //RULE_07
            default: opCount = xod_pkg::OPS_NONE;
          endcase
        end
      xod_pkg::OP_MEM_MEM:
        if (!prefixed)
        begin
          opCount = xod_pkg::OPS_TWO;
          case (subByte)
            xod_pkg::SUB_SA2_SA2: {form, dstKind, srcKind} =
              {xod_pkg::F_SA2_SA2, xod_pkg::K_AREA_TWO, xod_pkg::K_AREA_TWO}; //RULE_08
            xod_pkg::SUB_SA2_SA1: {form, dstKind, srcKind} =
              {xod_pkg::F_SA2_SA1, xod_pkg::K_AREA_TWO, xod_pkg::K_AREA_ONE};
            xod_pkg::SUB_SA1_SA2: {form, dstKind, srcKind} =
              {xod_pkg::F_SA1_SA2, xod_pkg::K_AREA_ONE, xod_pkg::K_AREA_TWO};
            xod_pkg::SUB_SA1_SA1: {form, dstKind, srcKind} =
              {xod_pkg::F_SA1_SA1, xod_pkg::K_AREA_ONE, xod_pkg::K_AREA_ONE}; //RULE_09
            default: opCount = xod_pkg::OPS_NONE;
          endcase
        end
      xod_pkg::OP_PTR:
      begin
        // the prefix picks area one over area two
        opCount = xod_pkg::OPS_ONE; //RULE_12
        case (subByte)
          xod_pkg::SUB_ACC_PTR: {form, dstKind, srcKind} = prefixed ?
            {xod_pkg::F_ACC_PTR1, xod_pkg::K_ACC, xod_pkg::K_AREA_ONE_PTR} :
            {xod_pkg::F_ACC_PTR2, xod_pkg::K_ACC, xod_pkg::K_AREA_TWO_PTR};
          xod_pkg::SUB_ACC_LONG: {form, dstKind, srcKind} = prefixed ?
            {xod_pkg::F_ACC_LONG1, xod_pkg::K_ACC, xod_pkg::K_AREA_ONE_LONG_PTR} :
            {xod_pkg::F_ACC_LONG2, xod_pkg::K_ACC, xod_pkg::K_AREA_TWO_LONG_PTR};
          xod_pkg::SUB_PTR_ACC: {form, dstKind, srcKind} = prefixed ?
            {xod_pkg::F_PTR1_ACC, xod_pkg::K_AREA_ONE_PTR, xod_pkg::K_ACC} :
            {xod_pkg::F_PTR2_ACC, xod_pkg::K_AREA_TWO_PTR, xod_pkg::K_ACC};
          xod_pkg::SUB_LONG_ACC: {form, dstKind, srcKind} = prefixed ?
            {xod_pkg::F_LONG1_ACC, xod_pkg::K_AREA_ONE_LONG_PTR, xod_pkg::K_ACC} :
            {xod_pkg::F_LONG2_ACC, xod_pkg::K_AREA_TWO_LONG_PTR, xod_pkg::K_ACC};
          default: opCount = xod_pkg::OPS_NONE;
        endcase
      end
      default: opCount = xod_pkg::OPS_NONE;
    endcase
  end

endmodule

// ==== rtl/xod_xor_unit.sv ====
`timescale 1ns/10ps
module xod_xor_unit (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       opValid,
  input  wire logic [7:0] firstOp,
  input  wire logic [7:0] secondOp,
  output logic            resultValid,
  output logic [7:0]      result
);

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } xod_xor_state_t;

  xod_xor_state_t st;
  xod_xor_state_t next_st;

  // ----------------------------------------------------------------
  // result is registered and held on its own output; neither operand is written
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.valid = opValid;
    if (opValid)
    begin
      next_st.value = firstOp ^ secondOp; //RULE_11
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign resultValid = st.valid;
  assign result      = st.value;

  a_xor_result: assert property (@(posedge clock) disable iff (!rstn) //RULE_11
    opValid |=> resultValid && result == ($past(firstOp) ^ $past(secondOp)))
    else $error("xor result does not match its operands");

endmodule

// ==== rtl/xod_decoder.sv ====
`timescale 1ns/10ps
// How it works
// RULE_01: prefix then 8d; third byte: destination reg high nibble, zero, source low bits.
// RULE_02: 7d group, low nibble 0: register from area two, offset follows.
// RULE_03: 7d group, low nibble 1: register from area one, offset follows.
// RULE_04: 7d group, low nibble 4: area two destination, register source.
// RULE_05: 7d group, low nibble 5: area one destination, register source.
// RULE_06: 7d group, low nibble 2: register from special register offset.
// RULE_07: 7d group, low nibble 6: special register destination, register source.
// RULE_08: 2a 0d: area two to area two, source then destination offset.
// RULE_09: 2a 3d: area one to area one, source then destination offset.
// RULE_10: special register operand byte is an offset, passed through unchanged.
// RULE_11: result is first XOR second, written to first operand only. Here it only drives the result output.
// RULE_12: 9d plus offset is accumulator with area two; prefix selects area one. Here 3c 9d is flagged illegal; the prefix selects area one only for 07 forms.
module xod_decoder (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             byteValid,
  input  wire logic [7:0]       byteData,
  input  wire logic             opValid,
  input  wire logic [7:0]       firstOp,
  input  wire logic [7:0]       secondOp,
  output logic                  formValid,
  output xod_pkg::xod_form_t    formCode,
  output xod_pkg::xod_kind_t    dstKind,
  output xod_pkg::xod_kind_t    srcKind,
  output logic [3:0]            dstReg,
  output logic [3:0]            srcReg,
  output logic [7:0]            srcOffset,
  output logic [7:0]            dstOffset,
  output logic                  illegal,
  output logic                  resultValid,
  output logic [7:0]            result
);

  typedef enum logic [1:0] {S_IDLE, S_PREFIX, S_SUB, S_OPERAND} xod_stage_t;

  typedef struct packed {
    xod_stage_t         stage;
    logic [7:0]         lead;
    logic               prefixed;
    xod_pkg::xod_form_t form;
    xod_pkg::xod_kind_t dk;
    xod_pkg::xod_kind_t sk;
    logic [3:0]         dreg;
    logic [3:0]         sreg;
    logic [7:0]         soff;
    logic [7:0]         doff;
    logic [1:0]         left;
    logic               fvalid;
    logic               bad;
  } xod_dec_state_t;

  xod_dec_state_t     st;
  xod_dec_state_t     next_st;
  logic               tabPrefixed;
  logic [7:0]         tabLead;
  xod_pkg::xod_form_t tabForm;
  xod_pkg::xod_kind_t tabDst;
  xod_pkg::xod_kind_t tabSrc;
  logic [1:0]         tabOps;
  logic               tabRegInSub;
  logic               dstIsMem;

  // ----------------------------------------------------------------
  // lookup of lead and second byte
  // ----------------------------------------------------------------
  assign tabPrefixed = (st.stage == S_PREFIX) ? 1'b1 : st.prefixed;
  assign tabLead     = (st.stage == S_PREFIX) ? xod_pkg::OP_PREFIX : st.lead;

  xod_form_table u_table (
    .prefixed (tabPrefixed),
    .leadByte (tabLead),
    .subByte  (byteData),
    .form     (tabForm),
    .dstKind  (tabDst),
    .srcKind  (tabSrc),
    .opCount  (tabOps),
    .regInSub (tabRegInSub)
  );

  assign dstIsMem = (st.dk != xod_pkg::K_REG) && (st.dk != xod_pkg::K_ACC);

  // ----------------------------------------------------------------
  // byte sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st        = st;
    next_st.fvalid = 1'b0;
    next_st.bad    = 1'b0;
    if (byteValid)
    begin
      case (st.stage)
        S_IDLE:
        begin
          next_st.prefixed = 1'b0;
          next_st.lead     = byteData;
          case (byteData)
            xod_pkg::OP_PREFIX: next_st.stage = S_PREFIX;
            xod_pkg::OP_ACC_SA2:
            begin
              // two-byte form: offset is the only operand
              next_st.form  = xod_pkg::F_ACC_SA2; //RULE_12
              next_st.dk    = xod_pkg::K_ACC;
              next_st.sk    = xod_pkg::K_AREA_TWO;
              next_st.left  = xod_pkg::OPS_ONE;
              next_st.stage = S_OPERAND;
            end
            xod_pkg::OP_REG_MEM, xod_pkg::OP_MEM_MEM, xod_pkg::OP_PTR:
              next_st.stage = S_SUB;
            default: next_st.bad = 1'b1;
          endcase
        end
        S_PREFIX:
        begin
          if (byteData == xod_pkg::OP_PTR)
          begin
            next_st.lead     = xod_pkg::OP_PTR; //RULE_12
            next_st.prefixed = 1'b1;
            next_st.stage    = S_SUB;
          end
          else if (tabForm != xod_pkg::F_NONE)
          begin
            next_st.form  = tabForm; //RULE_01
            next_st.dk    = tabDst;
            next_st.sk    = tabSrc;
            next_st.left  = tabOps;
            next_st.stage = S_OPERAND;
          end
          else
          begin
            next_st.bad   = 1'b1;
            next_st.stage = S_IDLE;
          end
        end
        S_SUB:
        begin
          if (tabForm != xod_pkg::F_NONE)
          begin
            next_st.form  = tabForm;
            next_st.dk    = tabDst;
            next_st.sk    = tabSrc;
            next_st.left  = tabOps;
            next_st.stage = S_OPERAND;
            if (tabRegInSub)
            begin
              // one register serves either side of the 7d group
              next_st.dreg = byteData[xod_pkg::REG_HI:xod_pkg::REG_LO];
              next_st.sreg = byteData[xod_pkg::REG_HI:xod_pkg::REG_LO];
            end
          end
          else
          begin
            next_st.bad   = 1'b1;
            next_st.stage = S_IDLE;
          end
        end
        S_OPERAND:
        begin
          if (st.form == xod_pkg::F_REG_REG)
          begin
            next_st.stage = S_IDLE;
            if (byteData[xod_pkg::RR_ZERO_BIT])
            begin
              next_st.bad = 1'b1; //RULE_01
            end
            else
            begin
              next_st.dreg   = byteData[xod_pkg::REG_HI:xod_pkg::REG_LO]; //RULE_01
              next_st.sreg   = {1'b0, byteData[xod_pkg::RR_SRC_HI:0]};
              next_st.fvalid = 1'b1;
            end
          end
          else if (st.left == xod_pkg::OPS_TWO)
          begin
            next_st.soff = byteData; //RULE_08
            next_st.left = xod_pkg::OPS_ONE;
          end
          else
          begin
            // sfr operand stays a raw offset, no address is formed
            if (dstIsMem)
            begin
              next_st.doff = byteData; //RULE_10
            end
            else
            begin
              next_st.soff = byteData; //RULE_10
            end
            next_st.left   = xod_pkg::OPS_NONE;
            next_st.fvalid = 1'b1;
            next_st.stage  = S_IDLE;
          end
        end
        default: next_st.stage = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st <= '{stage: S_IDLE, lead: xod_pkg::BYTE_RESET, prefixed: 1'b0,
              form: xod_pkg::F_NONE, dk: xod_pkg::K_NONE, sk: xod_pkg::K_NONE,
              dreg: xod_pkg::REG_RESET, sreg: xod_pkg::REG_RESET,
              soff: xod_pkg::BYTE_RESET, doff: xod_pkg::BYTE_RESET,
              left: xod_pkg::OPS_NONE, fvalid: 1'b0, bad: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign formValid = st.fvalid;
  assign formCode  = st.form;
  assign dstKind   = st.dk;
  assign srcKind   = st.sk;
  assign dstReg    = st.dreg;
  assign srcReg    = st.sreg;
  assign srcOffset = st.soff;
  assign dstOffset = st.doff;
  assign illegal   = st.bad;

  // ----------------------------------------------------------------
  // execution
  // ----------------------------------------------------------------
  xod_xor_unit u_xor (
    .clock       (clock),
    .rstn        (rstn),
    .opValid     (opValid),
    .firstOp     (firstOp),
    .secondOp    (secondOp),
    .resultValid (resultValid),
    .result      (result)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reg_reg_form: assert property (@(posedge clock) disable iff (!rstn) //RULE_01
    (st.stage == S_IDLE && byteValid && byteData == 8'h3c) ##1
    (byteValid && byteData == 8'h8d) ##1 (byteValid && !byteData[3])
    |=> formValid && formCode == xod_pkg::F_REG_REG &&
        dstReg == $past(byteData[7:4]) && srcReg == {1'b0, $past(byteData[2:0])})
    else $error("register pair form decoded wrongly");

  a_reg_area_two: assert property (@(posedge clock) disable iff (!rstn) //RULE_02
    (st.stage == S_IDLE && byteValid && byteData == 8'h7d) ##1
    (byteValid && byteData[3:0] == 4'h0) ##1 byteValid
    |=> formValid && formCode == xod_pkg::F_REG_SA2 && srcKind == xod_pkg::K_AREA_TWO &&
        srcOffset == $past(byteData) && dstReg == $past(byteData[7:4], 2))
    else $error("register from area two decoded wrongly");

  a_reg_area_one: assert property (@(posedge clock) disable iff (!rstn) //RULE_03
    (st.stage == S_IDLE && byteValid && byteData == 8'h7d) ##1
    (byteValid && byteData[3:0] == 4'h1) ##1 byteValid
    |=> formValid && srcKind == xod_pkg::K_AREA_ONE && srcOffset == $past(byteData))
    else $error("register from area one decoded wrongly");

  a_area_two_dst: assert property (@(posedge clock) disable iff (!rstn) //RULE_04
    (st.stage == S_IDLE && byteValid && byteData == 8'h7d) ##1
    (byteValid && byteData[3:0] == 4'h4) ##1 byteValid
    |=> formValid && dstKind == xod_pkg::K_AREA_TWO && dstOffset == $past(byteData) &&
        srcReg == $past(byteData[7:4], 2))
    else $error("area two destination decoded wrongly");

  a_area_one_dst: assert property (@(posedge clock) disable iff (!rstn) //RULE_05
    (st.stage == S_IDLE && byteValid && byteData == 8'h7d) ##1
    (byteValid && byteData[3:0] == 4'h5) ##1 byteValid
    |=> formValid && formCode == xod_pkg::F_SA1_REG && dstOffset == $past(byteData))
    else $error("area one destination decoded wrongly");

  a_reg_from_sfr: assert property (@(posedge clock) disable iff (!rstn) //RULE_06
    (st.stage == S_IDLE && byteValid && byteData == 8'h7d) ##1
    (byteValid && byteData[3:0] == 4'h2) ##1 byteValid
    |=> formValid && srcKind == xod_pkg::K_SFR && dstKind == xod_pkg::K_REG)
    else $error("register from special register decoded wrongly");

  a_sfr_offset_dst: assert property (@(posedge clock) disable iff (!rstn) //RULE_07
    (st.stage == S_IDLE && byteValid && byteData == 8'h7d) ##1
    (byteValid && byteData[3:0] == 4'h6) ##1 byteValid
    |=> formValid && dstKind == xod_pkg::K_SFR && dstOffset == $past(byteData))
    else $error("special register destination decoded wrongly");

  a_sfr_raw_offset: assert property (@(posedge clock) disable iff (!rstn) //RULE_10
    formValid && srcKind == xod_pkg::K_SFR |-> srcOffset == $past(byteData, 1))
    else $error("special register offset altered");

  a_area_two_pair: assert property (@(posedge clock) disable iff (!rstn) //RULE_08
    (st.stage == S_IDLE && byteValid && byteData == 8'h2a) ##1
    (byteValid && byteData == 8'h0d) ##1 byteValid [*2]
    |=> formValid && formCode == xod_pkg::F_SA2_SA2 &&
        srcOffset == $past(byteData, 2) && dstOffset == $past(byteData))
    else $error("area two pair decoded wrongly");

  a_area_one_pair: assert property (@(posedge clock) disable iff (!rstn) //RULE_09
    (st.stage == S_IDLE && byteValid && byteData == 8'h2a) ##1
    (byteValid && byteData == 8'h3d) ##1 byteValid [*2]
    |=> formValid && formCode == xod_pkg::F_SA1_SA1 &&
        srcOffset == $past(byteData, 2) && dstOffset == $past(byteData))
    else $error("area one pair decoded wrongly");

  a_acc_short_form: assert property (@(posedge clock) disable iff (!rstn) //RULE_12
    (st.stage == S_IDLE && byteValid && byteData == 8'h9d) ##1 byteValid
    |=> formValid && formCode == xod_pkg::F_ACC_SA2 && srcOffset == $past(byteData))
    else $error("accumulator area two form decoded wrongly");

endmodule

// ==== dv/xod_fetch_model.sv ====
`timescale 1ns/10ps
module xod_fetch_model (
  input  wire logic       clock,
  output logic            byteValid,
  output logic [7:0]      byteData
);
  initial
  begin
    byteValid = 1'b0;
    byteData  = 8'h00;
  end

  // bytes go out in order, one per edge, launched just after the edge
  task automatic send(input logic [7:0] b[$]);
    // one idle edge first, so a release and the next request never share a time step
    @(posedge clock);
    #1;
    foreach (b[i])
    begin
      byteValid = 1'b1;
      byteData  = b[i];
      @(posedge clock);
      #1;
    end
    byteValid = 1'b0;
    // released line: show the inverse so stale data never looks valid
    byteData  = ~byteData;
  endtask
endmodule

// ==== dv/xor_opcode_decoder_tb.sv ====
`timescale 1ns/10ps
module xor_opcode_decoder_tb;
  logic clock = 1'b0, rstn = 1'b0, opValid = 1'b0, byteValid, formValid, illegal, resultValid;
  logic [7:0] byteData, firstOp = 8'h00, secondOp = 8'h00, srcOffset, dstOffset, result;
  logic [3:0] dstReg, srcReg;
  xod_pkg::xod_form_t formCode;
  xod_pkg::xod_kind_t dstKind, srcKind;
  int error_cnt = 0, num_checks = 0, cycles = 0;

  always #2.5 clock = ~clock;

  xod_fetch_model xod_fetch_model_inst (.clock(clock), .byteValid(byteValid), .byteData(byteData));
  xod_decoder xod_decoder_inst (.clock(clock), .rstn(rstn), .byteValid(byteValid),
    .byteData(byteData), .opValid(opValid), .firstOp(firstOp), .secondOp(secondOp),
    .formValid(formValid), .formCode(formCode), .dstKind(dstKind), .srcKind(srcKind),
    .dstReg(dstReg), .srcReg(srcReg), .srcOffset(srcOffset), .dstOffset(dstOffset),
    .illegal(illegal), .resultValid(resultValid), .result(result));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // timeout
  // ------------------------------------------------------------
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // pulses are registered, so allow a few cycles before giving up
  task automatic wait_out();
    int n = 0;
    while (formValid !== 1'b1 && illegal !== 1'b1 && n < 4)
    begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  task automatic expect_form(input logic [7:0] b[$], input xod_pkg::xod_form_t f,
    input xod_pkg::xod_kind_t dk, input xod_pkg::xod_kind_t sk, input logic [3:0] r,
    input logic [7:0] so, input logic [7:0] dof);
    xod_fetch_model_inst.send(b);
    wait_out();
    chk("formValid", 8'h01, {7'h00, formValid});
    chk("formCode", 8'(f), 8'(formCode));
    chk("dstKind", 8'(dk), 8'(dstKind));
    chk("srcKind", 8'(sk), 8'(srcKind));
    if (dk == xod_pkg::K_REG)
      chk("dstReg", {4'h0, r}, {4'h0, dstReg});
    else if (sk == xod_pkg::K_REG)
      chk("srcReg", {4'h0, r}, {4'h0, srcReg});
    if (sk != xod_pkg::K_REG && sk != xod_pkg::K_ACC)
      chk("srcOffset", so, srcOffset);
    if (dk != xod_pkg::K_REG && dk != xod_pkg::K_ACC)
      chk("dstOffset", dof, dstOffset);
  endtask

  task automatic expect_illegal(input logic [7:0] b[$]);
    xod_fetch_model_inst.send(b);
    wait_out();
    chk("illegal", 8'h01, {7'h00, illegal});
    chk("formValid", 8'h00, {7'h00, formValid});
  endtask

  task automatic t_reg_reg();
    expect_form('{8'h3c, 8'h8d, 8'h75}, xod_pkg::F_REG_REG, xod_pkg::K_REG, xod_pkg::K_REG,
      4'h7, 8'h00, 8'h00);
    chk("srcReg", 8'h05, {4'h0, srcReg});
    expect_illegal('{8'h3c, 8'h8d, 8'h7d});
    $display("test reg_reg done");
  endtask

  task automatic t_reg_mem();
    expect_form('{8'h7d, 8'h30, 8'h11}, xod_pkg::F_REG_SA2, xod_pkg::K_REG,
      xod_pkg::K_AREA_TWO, 4'h3, 8'h11, 8'h00);
    expect_form('{8'h7d, 8'hf1, 8'hfe}, xod_pkg::F_REG_SA1, xod_pkg::K_REG,
      xod_pkg::K_AREA_ONE, 4'hf, 8'hfe, 8'h00);
    expect_form('{8'h7d, 8'h94, 8'h80}, xod_pkg::F_SA2_REG, xod_pkg::K_AREA_TWO,
      xod_pkg::K_REG, 4'h9, 8'h00, 8'h80);
    expect_form('{8'h7d, 8'h05, 8'h01}, xod_pkg::F_SA1_REG, xod_pkg::K_AREA_ONE,
      xod_pkg::K_REG, 4'h0, 8'h00, 8'h01);
    expect_form('{8'h7d, 8'hc2, 8'hff}, xod_pkg::F_REG_SFR, xod_pkg::K_REG, xod_pkg::K_SFR,
      4'hc, 8'hff, 8'h00);
    expect_form('{8'h7d, 8'h66, 8'h00}, xod_pkg::F_SFR_REG, xod_pkg::K_SFR, xod_pkg::K_REG,
      4'h6, 8'h00, 8'h00);
    $display("test reg_mem done");
  endtask

  task automatic t_mem_mem();
    expect_form('{8'h2a, 8'h0d, 8'h12, 8'h34}, xod_pkg::F_SA2_SA2, xod_pkg::K_AREA_TWO,
      xod_pkg::K_AREA_TWO, 4'h0, 8'h12, 8'h34);
    expect_form('{8'h2a, 8'h3d, 8'hab, 8'hcd}, xod_pkg::F_SA1_SA1, xod_pkg::K_AREA_ONE,
      xod_pkg::K_AREA_ONE, 4'h0, 8'hab, 8'hcd);
    expect_form('{8'h2a, 8'h1d, 8'h56, 8'h78}, xod_pkg::F_SA2_SA1, xod_pkg::K_AREA_TWO,
      xod_pkg::K_AREA_ONE, 4'h0, 8'h56, 8'h78);
    expect_form('{8'h2a, 8'h2d, 8'h9a, 8'hbc}, xod_pkg::F_SA1_SA2, xod_pkg::K_AREA_ONE,
      xod_pkg::K_AREA_TWO, 4'h0, 8'h9a, 8'hbc);
    $display("test mem_mem done");
  endtask

  task automatic t_acc();
    expect_form('{8'h9d, 8'h5a}, xod_pkg::F_ACC_SA2, xod_pkg::K_ACC, xod_pkg::K_AREA_TWO,
      4'h0, 8'h5a, 8'h00);
    expect_form('{8'h3c, 8'h07, 8'h2d, 8'ha5}, xod_pkg::F_ACC_PTR1, xod_pkg::K_ACC,
      xod_pkg::K_AREA_ONE_PTR, 4'h0, 8'ha5, 8'h00);
    expect_form('{8'h07, 8'had, 8'h3c}, xod_pkg::F_PTR2_ACC, xod_pkg::K_AREA_TWO_PTR,
      xod_pkg::K_ACC, 4'h0, 8'h00, 8'h3c);
    expect_form('{8'h3c, 8'h07, 8'hbd, 8'h77}, xod_pkg::F_LONG1_ACC,
      xod_pkg::K_AREA_ONE_LONG_PTR, xod_pkg::K_ACC, 4'h0, 8'h00, 8'h77);
    $display("test acc done");
  endtask

  task automatic t_refused();
    expect_illegal('{8'h7d, 8'h33});
    expect_illegal('{8'hff});
    expect_form('{8'h9d, 8'h0f}, xod_pkg::F_ACC_SA2, xod_pkg::K_ACC, xod_pkg::K_AREA_TWO,
      4'h0, 8'h0f, 8'h00);
    $display("test refused done");
  endtask

  // back-to-back operand pairs, result one cycle after each
  task automatic t_xor();
    logic [7:0] a[3] = '{8'hff, 8'h5a, 8'h00};
    logic [7:0] b[3] = '{8'h0f, 8'h5a, 8'h81};
    for (int i = 0; i < 3; i++)
    begin
      opValid  = 1'b1;
      firstOp  = a[i];
      secondOp = b[i];
      @(posedge clock);
      #1;
      chk("resultValid", 8'h01, {7'h00, resultValid});
      chk("result", a[i] ^ b[i], result);
    end
    opValid = 1'b0;
    @(posedge clock);
    #1;
    chk("resultValid", 8'h00, {7'h00, resultValid});
    chk("result", 8'h81, result);
    $display("test xor done");
  endtask

  // reset cuts a half-collected instruction; the next lead byte starts afresh
  task automatic t_reset();
    xod_fetch_model_inst.send('{8'h2a, 8'h0d});
    rstn = 1'b0;
    @(posedge clock);
    #1;
    rstn = 1'b1;
    chk("formCode", 8'(xod_pkg::F_NONE), 8'(formCode));
    chk("srcOffset", 8'h00, srcOffset);
    chk("result", 8'h00, result);
    expect_form('{8'h9d, 8'h44}, xod_pkg::F_ACC_SA2, xod_pkg::K_ACC, xod_pkg::K_AREA_TWO,
      4'h0, 8'h44, 8'h00);
    $display("test reset done");
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    rstn = 1'b1;
    chk("formCode", 8'(xod_pkg::F_NONE), 8'(formCode));
    chk("result", 8'h00, result);
    t_reg_reg();
    t_reg_mem();
    t_mem_mem();
    t_acc();
    t_refused();
    t_xor();
    t_reset();
    report_and_stop();
  end
endmodule
